//--- mbs_pkg.sv
// constants, types and register map of the mechanical brake sequencer
// assumes one control clock shared with the drive speed control logic
package mbs_pkg;

	// apb register byte addresses
	localparam logic [7:0] ADDR_CTRL      = 8'h00;
	localparam logic [7:0] ADDR_OPEN_DLY  = 8'h04;
	localparam logic [7:0] ADDR_CLOSE_DLY = 8'h08;
	localparam logic [7:0] ADDR_CLOSE_LVL = 8'h0C;
	localparam logic [7:0] ADDR_STATUS    = 8'h10;
	localparam logic [7:0] ADDR_SPEED     = 8'h14;
	localparam logic [7:0] ADDR_CLOSE_CNT = 8'h18;

	// widths
	localparam int unsigned AW    = 8;
	localparam int unsigned DW    = 32;
	localparam int unsigned DLY_W = 16;
	localparam int unsigned SPD_W = 16;
	localparam int unsigned CNT_W = 16;

	// control and status register fields
	localparam int unsigned CTRL_EN_BIT   = 0;
	localparam int unsigned CTRL_RSEL_LSB = 1;
	localparam int unsigned RSEL_W        = 2;
	localparam int unsigned STAT_W        = 5;
	localparam int unsigned STATE_LSB     = 8;
	localparam int unsigned STATE_W       = 3;

	// reset values and the close counter step
	localparam logic             CTRL_EN_RST   = 1'b0;
	localparam logic [DLY_W-1:0] OPEN_DLY_RST  = 16'h0000;
	localparam logic [DLY_W-1:0] CLOSE_DLY_RST = 16'h0000;
	localparam logic [SPD_W-1:0] CLOSE_LVL_RST = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE       = 16'h0001;

	// what the relay output follows
	typedef enum logic [1:0] {
		RSEL_BRAKE_CMD = 2'b00,
		RSEL_OFF       = 2'b01,
		RSEL_ON        = 2'b10,
		RSEL_BRAKE_INV = 2'b11
	} mbs_rsel_e;

	// sequencer states
	typedef enum logic [2:0] {
		ST_DISABLED      = 3'b000,
		ST_OPENING       = 3'b001,
		ST_OPEN          = 3'b010,
		ST_CLOSING_WAIT  = 3'b011,
		ST_CLOSING_DELAY = 3'b100,
		ST_CLOSED        = 3'b101
	} mbs_state_e;

	// brake status word: b0 open, b1 spare, b2 hold, b3 ramp-down, b4 enabled
	typedef struct packed {
		logic enabled;
		logic ramp_req;
		logic hold_req;
		logic spare;
		logic brake_open;
	} mbs_status_s;

	// signals taken from the drive control logic
	typedef struct packed {
		logic             start_cmd;
		logic             run_status;
		logic [SPD_W-1:0] speed;
	} mbs_drive_in_s;

endpackage

//--- mbs_delay_timer.sv
// delay timer counted in control cycles, restarted on state entry
// assumes restart is a one-cycle pulse and active stays high while in the state
module mbs_delay_timer (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      restart,
	input  wire logic                      active,
	input  wire logic [mbs_pkg::DLY_W-1:0] limit,
	output logic                           done
);

	logic [mbs_pkg::DLY_W-1:0] cnt_r;
	logic                      done_r;

	// count up while active, stop at the limit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
		end else if (restart) begin
			cnt_r <= '0;
		end else if (active && cnt_r < limit) begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	// expiry flag, dropped on restart
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_r <= 1'b0;
		end else begin
			done_r <= active && !restart && cnt_r >= limit;
		end
	end

	assign done = done_r;

endmodule

//--- mbs_speed_cmp.sv
// magnitude of the signed motor speed and its comparison to the close level
// assumes speed arrives from logic on the same clock
module mbs_speed_cmp (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic [mbs_pkg::SPD_W-1:0] speed,
	input  wire logic [mbs_pkg::SPD_W-1:0] level,
	output logic [mbs_pkg::SPD_W-1:0]      speed_abs,
	output logic                           below
);

	logic [mbs_pkg::SPD_W-1:0] abs_r;
	logic                      below_r;
	logic [mbs_pkg::SPD_W-1:0] mag;

	// two's complement magnitude, sign bit on top
	assign mag = speed[mbs_pkg::SPD_W-1] ? (~speed + 1'b1) : speed;

	// registered magnitude and strict below-level flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			abs_r   <= '0;
			below_r <= 1'b0;
		end else begin
			abs_r   <= mag;
			below_r <= mag < level;
		end
	end

	assign speed_abs = abs_r;
	assign below     = below_r;

endmodule

//--- mbs_brake_seq.sv
// mechanical brake sequencer with apb register access
// assumes drive inputs come from logic on pclk, so they are not synchronised
module mbs_brake_seq (
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [mbs_pkg::AW-1:0]       paddr,
	input  wire logic [mbs_pkg::DW-1:0]       pwdata,
	output logic [mbs_pkg::DW-1:0]            prdata,
	output logic                              pready,
	output logic                              pslverr,
	input  wire mbs_pkg::mbs_drive_in_s       drive_in,
	output mbs_pkg::mbs_status_s              brake_status,
	output logic                              relay_out,
	output logic [mbs_pkg::STATE_W-1:0]       seq_state
);

	// register file
	logic                      ctrl_en_r;
	mbs_pkg::mbs_rsel_e        relay_one_source_select_r;
	logic [mbs_pkg::DLY_W-1:0] open_dly_r;
	logic [mbs_pkg::DLY_W-1:0] close_dly_r;
	logic [mbs_pkg::SPD_W-1:0] close_lvl_r;
	logic [mbs_pkg::CNT_W-1:0] close_cnt_r;

	// apb slave state
	logic                      pready_r;
	logic                      pslverr_r;
	logic [mbs_pkg::DW-1:0]    prdata_r;
	logic [mbs_pkg::DW-1:0]    rdata_nxt;
	logic                      addr_ok;
	logic                      acc_wait;
	logic                      acc_done;

	// sequencer state and outputs
	mbs_pkg::mbs_state_e       state_r;
	mbs_pkg::mbs_state_e       state_nxt;
	mbs_pkg::mbs_status_s      status_r;
	mbs_pkg::mbs_status_s      status_nxt;
	logic                      relay_r;
	logic                      relay_nxt;

	// derived conditions
	logic                      open_req;
	logic                      close_req;
	logic                      run_lost;
	logic                      open_dly_done;
	logic                      close_dly_done;
	logic                      open_dly_restart;
	logic                      close_dly_restart;
	logic                      speed_below;
	logic [mbs_pkg::SPD_W-1:0] speed_abs;

	// ------------------------------------------------------------------
	// apb slave: one wait cycle, answer registered
	// ------------------------------------------------------------------

	// first access cycle prepares the answer, second completes it
	assign acc_wait = psel && penable && !pready_r;
	assign acc_done = psel && penable && pready_r;

	// address decode of every mapped word
	always_comb begin
		unique case (paddr)
			mbs_pkg::ADDR_CTRL,
			mbs_pkg::ADDR_OPEN_DLY,
			mbs_pkg::ADDR_CLOSE_DLY,
			mbs_pkg::ADDR_CLOSE_LVL,
			mbs_pkg::ADDR_STATUS,
			mbs_pkg::ADDR_SPEED,
			mbs_pkg::ADDR_CLOSE_CNT: addr_ok = 1'b1;
			default:                 addr_ok = 1'b0;
		endcase
	end

	// read data mux, unused upper bits read as zero
	always_comb begin
		rdata_nxt = '0;
		unique case (paddr)
			mbs_pkg::ADDR_CTRL: begin
				rdata_nxt[mbs_pkg::CTRL_EN_BIT] = ctrl_en_r;
				rdata_nxt[mbs_pkg::CTRL_RSEL_LSB +: mbs_pkg::RSEL_W] = relay_one_source_select_r;
			end
			mbs_pkg::ADDR_OPEN_DLY: begin
				rdata_nxt[mbs_pkg::DLY_W-1:0] = open_dly_r;
			end
			mbs_pkg::ADDR_CLOSE_DLY: begin
				rdata_nxt[mbs_pkg::DLY_W-1:0] = close_dly_r;
			end
			mbs_pkg::ADDR_CLOSE_LVL: begin
				rdata_nxt[mbs_pkg::SPD_W-1:0] = close_lvl_r;
			end
			mbs_pkg::ADDR_STATUS: begin
				rdata_nxt[mbs_pkg::STAT_W-1:0] = status_r;
				rdata_nxt[mbs_pkg::STATE_LSB +: mbs_pkg::STATE_W] = state_r;
			end
			mbs_pkg::ADDR_SPEED: begin
				rdata_nxt[mbs_pkg::SPD_W-1:0] = speed_abs;
			end
			mbs_pkg::ADDR_CLOSE_CNT: begin
				rdata_nxt[mbs_pkg::CNT_W-1:0] = close_cnt_r;
			end
			default: begin
				rdata_nxt = '0;
			end
		endcase
	end

	// handshake flops: pready high for exactly one cycle per transfer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= acc_wait;
			pslverr_r <= acc_wait && !addr_ok;
		end
	end

	// read data captured in the wait cycle, cleared otherwise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= '0;
		end else if (acc_wait && !pwrite) begin
			prdata_r <= rdata_nxt;
		end else begin
			prdata_r <= '0;
		end
	end

	// control register, written at the completing edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_en_r                 <= mbs_pkg::CTRL_EN_RST;
			relay_one_source_select_r <= mbs_pkg::RSEL_BRAKE_CMD;
		end else if (acc_done && pwrite && paddr == mbs_pkg::ADDR_CTRL) begin
			ctrl_en_r                 <= pwdata[mbs_pkg::CTRL_EN_BIT];
			relay_one_source_select_r <= mbs_pkg::mbs_rsel_e'(pwdata[mbs_pkg::CTRL_RSEL_LSB +: mbs_pkg::RSEL_W]);
		end
	end

	// delay and level settings
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			open_dly_r  <= mbs_pkg::OPEN_DLY_RST;
			close_dly_r <= mbs_pkg::CLOSE_DLY_RST;
			close_lvl_r <= mbs_pkg::CLOSE_LVL_RST;
		end else if (acc_done && pwrite) begin
			if (paddr == mbs_pkg::ADDR_OPEN_DLY) begin
				open_dly_r <= pwdata[mbs_pkg::DLY_W-1:0];
			end
			if (paddr == mbs_pkg::ADDR_CLOSE_DLY) begin
				close_dly_r <= pwdata[mbs_pkg::DLY_W-1:0];
			end
			if (paddr == mbs_pkg::ADDR_CLOSE_LVL) begin
				close_lvl_r <= pwdata[mbs_pkg::SPD_W-1:0];
			end
		end
	end

	// ------------------------------------------------------------------
	// request conditions taken from the drive
	// ------------------------------------------------------------------

	assign open_req  = drive_in.start_cmd;
	assign close_req = !drive_in.start_cmd;

	assign run_lost = !drive_in.run_status;

	mbs_speed_cmp u_speed_cmp (
		.pclk      (pclk),
		.presetn   (presetn),
		.speed     (drive_in.speed),
		.level     (close_lvl_r),
		.speed_abs (speed_abs),
		.below     (speed_below)
	);

	assign open_dly_restart  = state_nxt == mbs_pkg::ST_OPENING && state_r != mbs_pkg::ST_OPENING;
	assign close_dly_restart = state_nxt == mbs_pkg::ST_CLOSING_DELAY && state_r != mbs_pkg::ST_CLOSING_DELAY;

	mbs_delay_timer u_open_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.restart (open_dly_restart),
		.active  (state_r == mbs_pkg::ST_OPENING),
		.limit   (open_dly_r),
		.done    (open_dly_done)
	);

	mbs_delay_timer u_close_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.restart (close_dly_restart),
		.active  (state_r == mbs_pkg::ST_CLOSING_DELAY),
		.limit   (close_dly_r),
		.done    (close_dly_done)
	);

	// ------------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------------

	// next-state logic; disable overrides every other condition
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			mbs_pkg::ST_DISABLED: begin
				if (ctrl_en_r) begin
					state_nxt = mbs_pkg::ST_CLOSED;
				end
			end
			mbs_pkg::ST_OPENING: begin
				if (run_lost) begin
					state_nxt = mbs_pkg::ST_CLOSED;
				end else if (open_dly_done) begin
					state_nxt = mbs_pkg::ST_OPEN;
				end
			end
			mbs_pkg::ST_OPEN: begin
				if (run_lost) begin
					state_nxt = mbs_pkg::ST_CLOSED;
				end else if (close_req) begin
					state_nxt = mbs_pkg::ST_CLOSING_WAIT;
				end
			end
			mbs_pkg::ST_CLOSING_WAIT: begin
				if (speed_below || run_lost) begin
					state_nxt = mbs_pkg::ST_CLOSING_DELAY;
				end else if (open_req) begin
					state_nxt = mbs_pkg::ST_OPENING;
				end
			end
			mbs_pkg::ST_CLOSING_DELAY: begin
				if (close_dly_done) begin
					state_nxt = mbs_pkg::ST_CLOSED;
				end
			end
			mbs_pkg::ST_CLOSED: begin
				if (open_req && !run_lost) begin
					state_nxt = mbs_pkg::ST_OPENING;
				end
			end
			default: begin
				state_nxt = mbs_pkg::ST_CLOSED;
			end
		endcase
		if (!ctrl_en_r) begin
			state_nxt = mbs_pkg::ST_DISABLED;
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= mbs_pkg::ST_DISABLED;
		end else begin
			state_r <= state_nxt;
		end
	end

	// status word decoded from the next state so it lines up with state_r
	always_comb begin
		status_nxt = '0;
		unique case (state_nxt)
			mbs_pkg::ST_DISABLED: begin
				status_nxt.brake_open = 1'b1;
			end
			mbs_pkg::ST_OPENING: begin
				status_nxt.enabled    = 1'b1;
				status_nxt.hold_req   = 1'b1;
				status_nxt.brake_open = 1'b1;
			end
			mbs_pkg::ST_OPEN: begin
				status_nxt.enabled    = 1'b1;
				status_nxt.brake_open = 1'b1;
			end
			mbs_pkg::ST_CLOSING_WAIT: begin
				status_nxt.enabled    = 1'b1;
				status_nxt.ramp_req   = 1'b1;
				status_nxt.brake_open = 1'b1;
			end
			mbs_pkg::ST_CLOSING_DELAY: begin
				status_nxt.enabled    = 1'b1;
				status_nxt.ramp_req   = 1'b1;
			end
			mbs_pkg::ST_CLOSED: begin
				status_nxt.enabled    = 1'b1;
			end
			default: begin
				status_nxt = '0;
			end
		endcase
	end

	always_comb begin
		unique case (relay_one_source_select_r)
			mbs_pkg::RSEL_BRAKE_CMD: relay_nxt = status_nxt.brake_open;
			mbs_pkg::RSEL_OFF:       relay_nxt = 1'b0;
			mbs_pkg::RSEL_ON:        relay_nxt = 1'b1;
			mbs_pkg::RSEL_BRAKE_INV: relay_nxt = !status_nxt.brake_open;
		endcase
	end

	// registered status and relay drive
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_r <= '0;
			relay_r  <= 1'b0;
		end else begin
			status_r <= status_nxt;
			relay_r  <= relay_nxt;
		end
	end

	// count of completed closing sequences, wraps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			close_cnt_r <= '0;
		end else if (state_r == mbs_pkg::ST_CLOSING_DELAY && state_nxt == mbs_pkg::ST_CLOSED) begin
			close_cnt_r <= close_cnt_r + mbs_pkg::CNT_ONE;
		end
	end

	// outputs straight from flops
	assign prdata       = prdata_r;
	assign pready       = pready_r;
	assign pslverr      = pslverr_r;
	assign brake_status = status_r;
	assign relay_out    = relay_r;
	assign seq_state    = state_r;

endmodule

//--- mbs_brake_seq_assertions.sv
// checker tying the brake sequencer status flags and state moves to its state code
// assumes it is bound into mbs_brake_seq, one clock, async active-low reset
module mbs_brake_seq_assertions (
	input wire logic                         pclk,
	input wire logic                         presetn,
	input wire logic                         psel,
	input wire logic                         penable,
	input wire logic                         pwrite,
	input wire logic [mbs_pkg::AW-1:0]       paddr,
	input wire logic [mbs_pkg::DW-1:0]       pwdata,
	input wire logic [mbs_pkg::DW-1:0]       prdata,
	input wire logic                         pready,
	input wire logic                         pslverr,
	input wire mbs_pkg::mbs_drive_in_s       drive_in,
	input wire mbs_pkg::mbs_status_s         brake_status,
	input wire logic                         relay_out,
	input wire logic [mbs_pkg::STATE_W-1:0]  seq_state
);
	timeunit 1ns;
	timeprecision 1ns;
	logic up_r;

	// masks the first edge after release, outputs still hold reset zeros
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			up_r <= 1'b0;
		else
			up_r <= 1'b1;
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn || !up_r);

	AST_DIS_FLAGS: assert property (seq_state == mbs_pkg::ST_DISABLED |->
		!brake_status.enabled && brake_status.brake_open) else $error("disabled flags wrong");
	AST_OPENING_HOLD: assert property (seq_state == mbs_pkg::ST_OPENING |->
		brake_status.hold_req && brake_status.brake_open) else $error("opening flags wrong");
	AST_OPEN_FREE: assert property (seq_state == mbs_pkg::ST_OPEN |->
		brake_status.brake_open && !brake_status.hold_req) else $error("open flags wrong");
	AST_CW_RAMP: assert property (seq_state == mbs_pkg::ST_CLOSING_WAIT |->
		brake_status.ramp_req && brake_status.brake_open) else $error("closing wait flags wrong");
	AST_CW_EXIT: assert property (seq_state == mbs_pkg::ST_CLOSING_WAIT ##1
		seq_state != mbs_pkg::ST_CLOSING_WAIT |-> seq_state inside {mbs_pkg::ST_CLOSING_DELAY,
		mbs_pkg::ST_OPENING, mbs_pkg::ST_DISABLED}) else $error("closing wait left wrongly");
	AST_CD_DROP: assert property (seq_state == mbs_pkg::ST_CLOSING_DELAY |->
		brake_status.ramp_req && !brake_status.brake_open) else $error("closing delay flags wrong");
	AST_CD_EXIT: assert property ($rose(seq_state == mbs_pkg::ST_CLOSING_DELAY) |=>
		seq_state == mbs_pkg::ST_CLOSING_DELAY [*2] or seq_state == mbs_pkg::ST_DISABLED)
		else $error("closing delay too short");
	AST_CLOSED_SHUT: assert property (seq_state == mbs_pkg::ST_CLOSED |->
		!brake_status.brake_open) else $error("closed but brake open");
	AST_LEAVE_DIS: assert property (seq_state == mbs_pkg::ST_DISABLED ##1
		seq_state != mbs_pkg::ST_DISABLED |-> seq_state == mbs_pkg::ST_CLOSED)
		else $error("left disabled wrongly");
	AST_OPEN_ENTRY: assert property ($rose(seq_state == mbs_pkg::ST_OPEN) |->
		$past(seq_state) == mbs_pkg::ST_OPENING) else $error("open not from opening");
	AST_CLOSE_REQ: assert property (seq_state == mbs_pkg::ST_OPEN && !drive_in.start_cmd &&
		drive_in.run_status |=> seq_state inside {mbs_pkg::ST_CLOSING_WAIT, mbs_pkg::ST_DISABLED})
		else $error("close request ignored");
	AST_OPEN_REQ: assert property (seq_state == mbs_pkg::ST_CLOSED && drive_in.start_cmd &&
		drive_in.run_status |=> seq_state inside {mbs_pkg::ST_OPENING, mbs_pkg::ST_DISABLED})
		else $error("open request ignored");
	AST_RUN_LOST: assert property (seq_state inside {mbs_pkg::ST_OPENING, mbs_pkg::ST_OPEN} &&
		!drive_in.run_status |=> seq_state inside {mbs_pkg::ST_CLOSED, mbs_pkg::ST_DISABLED})
		else $error("run loss not closing");

	// main scenarios
	cover property ($rose(seq_state == mbs_pkg::ST_OPEN));
	cover property (seq_state == mbs_pkg::ST_CLOSING_DELAY);
	cover property (pready && pslverr);
endmodule

bind mbs_brake_seq mbs_brake_seq_assertions mbs_brake_seq_assertions_inst (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .drive_in(drive_in),
	.brake_status(brake_status), .relay_out(relay_out), .seq_state(seq_state));

//--- mbs_drive_model.sv
// model of the drive speed control and the brake relay actuator
// assumes the bench sets start command and run permission on pclk
module mbs_drive_model (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 start,
	input  wire logic                 run_ok,
	input  wire mbs_pkg::mbs_status_s brake_status,
	input  wire logic                 relay_out,
	output mbs_pkg::mbs_drive_in_s    drive_in,
	output logic                      brake_engaged
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] speed_r;

	assign drive_in = {start, run_ok, speed_r};

	// hold keeps speed, ramp request brings it down, else rise by 5 up to 100 while start and brake open
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			speed_r <= 16'h0000;
		else if (brake_status.ramp_req)
			speed_r <= (speed_r > 16'h0005) ? speed_r - 16'h0005 : 16'h0000;
		else if (brake_status.brake_open && !brake_status.hold_req && start && speed_r < 16'h0064)
			speed_r <= speed_r + 16'h0005;
	end

	assign brake_engaged = !relay_out;
endmodule

//--- mbs_brake_seq_bench.sv
// self-checking bench of the brake sequencer over apb
// assumes the drive model stands at the far side of the sequencer
module mbs_brake_seq_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic                  relay_out, start, run_ok, brake_engaged;
	logic [7:0]            paddr;
	logic [31:0]           pwdata, prdata;
	logic [2:0]            seq_state;
	mbs_pkg::mbs_drive_in_s drive_in;
	mbs_pkg::mbs_status_s  brake_status;
	int                    n_fail = 0;
	int                    cmp_count = 0;
	logic [7:0]            ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
	logic [31:0]           rv [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_0001, 32'h0, 32'h0};
	logic [3:0]            rx = 4'h5;

	mbs_brake_seq mbs_brake_seq_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .drive_in(drive_in), .brake_status(brake_status), .relay_out(relay_out),
		.seq_state(seq_state));
	mbs_drive_model mbs_drive_model_inst (.pclk(pclk), .presetn(presetn), .start(start),
		.run_ok(run_ok), .brake_status(brake_status), .relay_out(relay_out), .drive_in(drive_in),
		.brake_engaged(brake_engaged));

	// clock, 50 ns period
	always #25 pclk = ~pclk;

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic xe,
		output logic [31:0] q);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no cycle count assumed, a hung transfer is ended by the watchdog
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		chk("pslverr", {31'h0, xe}, {31'h0, pslverr});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
		logic [31:0] q;
		apb(1'b1, a, d, xe, q);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic xe);
		logic [31:0] q;
		apb(1'b0, a, 32'h0, xe, q);
		chk("prdata", exp, q);
	endtask

	task automatic wait_st(input logic [2:0] s, output int n);
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (seq_state !== s && n < 300);
		chk("seq_state", {29'h0, s}, {29'h0, seq_state});
	endtask

	task automatic span(input logic [2:0] s, output int n);
		n = 0;
		while (seq_state === s && n < 300) begin
			n++;
			@(posedge pclk);
		end
	endtask

	task automatic sts(input logic [4:0] x);
		chk("brake_status", {27'h0, x}, {27'h0, brake_status});
	endtask

	task final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// watchdog against a hung handshake, state waits give up by themselves after 300 cycles
	initial begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		final_report();
	end

	initial begin
		int n;
		pclk = 0;
		presetn = 0;
		{psel, penable, pwrite, paddr, pwdata, start} = '0;
		run_ok = 1;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		foreach (ra[i]) rd(ra[i], rv[i], 1'b0);
		rd(8'h1C, 32'h0, 1'b1);
		wr(8'h1C, 32'hFFFF_FFFF, 1'b1);
		wr(mbs_pkg::ADDR_STATUS, 32'h0000_001E, 1'b0);
		rd(mbs_pkg::ADDR_STATUS, 32'h0000_0001, 1'b0);
		// relay source in each mode while the brake bit is high
		for (int i = 0; i < 4; i++) begin
			wr(mbs_pkg::ADDR_CTRL, {29'h0, 2'(i), 1'b0}, 1'b0);
			repeat (2) @(posedge pclk);
			chk("relay_out", {31'h0, rx[i]}, {31'h0, relay_out});
		end
		wr(mbs_pkg::ADDR_OPEN_DLY, 32'h0000_0003, 1'b0);
		wr(mbs_pkg::ADDR_CLOSE_DLY, 32'h0000_0002, 1'b0);
		wr(mbs_pkg::ADDR_CLOSE_LVL, 32'h0000_000A, 1'b0);
		rd(mbs_pkg::ADDR_OPEN_DLY, 32'h0000_0003, 1'b0);
		wr(mbs_pkg::ADDR_CTRL, 32'h0000_0001, 1'b0);
		wait_st(mbs_pkg::ST_CLOSED, n);
		sts(5'h10);
		// full open and close sequence
		start <= 1'b1;
		wait_st(mbs_pkg::ST_OPENING, n);
		sts(5'h15);
		span(mbs_pkg::ST_OPENING, n);
		chk("open span", 32'h5, n);
		sts(5'h11);
		rd(mbs_pkg::ADDR_STATUS, 32'h0000_0211, 1'b0);
		repeat (25) @(posedge pclk);
		start <= 1'b0;
		wait_st(mbs_pkg::ST_CLOSING_WAIT, n);
		sts(5'h19);
		wait_st(mbs_pkg::ST_CLOSING_DELAY, n);
		sts(5'h18);
		span(mbs_pkg::ST_CLOSING_DELAY, n);
		chk("close span", 32'h4, n);
		chk("engaged", 32'h1, {31'h0, brake_engaged});
		rd(mbs_pkg::ADDR_CLOSE_CNT, 32'h0000_0001, 1'b0);
		// run lost while opening
		start <= 1'b1;
		wait_st(mbs_pkg::ST_OPENING, n);
		run_ok <= 1'b0;
		wait_st(mbs_pkg::ST_CLOSED, n);
		chk("drop time", 32'h2, n);
		sts(5'h10);
		run_ok <= 1'b1;
		wait_st(mbs_pkg::ST_OPEN, n);
		// start returns while still ramping down, brake reopens
		repeat (10) @(posedge pclk);
		start <= 1'b0;
		wait_st(mbs_pkg::ST_CLOSING_WAIT, n);
		start <= 1'b1;
		wait_st(mbs_pkg::ST_OPENING, n);
		chk("reopen time", 32'h2, n);
		wait_st(mbs_pkg::ST_OPEN, n);
		wr(mbs_pkg::ADDR_CTRL, 32'h0, 1'b0);
		wait_st(mbs_pkg::ST_DISABLED, n);
		chk("disable time", 32'h2, n);
		sts(5'h01);
		final_report();
	end
endmodule
